// File: logic/sbbu_consts.svh
`ifndef SBBU_CONSTS_SVH
`define SBBU_CONSTS_SVH

// Reset values of the program counter and the code page
`define SBBU_PC_RESET 16'h0000
`define SBBU_PAGE_RESET 16'h0000

// Bit positions inside the condition-code vectors
`define SBBU_FLG_C 0
`define SBBU_FLG_V 1
`define SBBU_FLG_Z 2
`define SBBU_FLG_N 3

// Condition-code write masks
`define SBBU_CCR_NONE 4'h0
`define SBBU_CCR_ALL 4'hF
`define SBBU_CCR_Z 4'h4

// Bit-number fold for byte operands
`define SBBU_BYTE_POS_MASK 4'h7

`endif

// File: logic/sbbu_pkg.sv
package sbbu_pkg;

  // Operation codes handled by the unit
  typedef enum logic [4:0] {
    OP_ARITH_SHIFT_LEFT = 5'h00,
    OP_ARITH_SHIFT_RIGHT = 5'h01,
    OP_LOGIC_SHIFT_LEFT = 5'h02,
    OP_LOGIC_SHIFT_RIGHT = 5'h03,
    OP_ROTATE_LEFT = 5'h04,
    OP_ROTATE_RIGHT = 5'h05,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h06,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h07,
    OP_BIT_SET = 5'h08,
    OP_BIT_CLEAR = 5'h09,
    OP_BIT_INVERT = 5'h0A,
    OP_BIT_TEST = 5'h0B,
    OP_COND_BRANCH = 5'h0C,
    OP_SAME_PAGE_JUMP = 5'h0D,
    OP_PAGE_JUMP = 5'h0E,
    OP_RELATIVE_CALL = 5'h0F,
    OP_ABSOLUTE_CALL = 5'h10,
    OP_PAGE_CALL = 5'h11,
    OP_SAME_PAGE_RETURN = 5'h12
  } sbbu_op_t;

  // Branch conditions
  typedef enum logic [3:0] {
    COND_ALWAYS = 4'h0,
    COND_NEVER = 4'h1,
    COND_HIGHER = 4'h2,
    COND_LOWER_SAME = 4'h3,
    COND_CARRY_CLEAR = 4'h4,
    COND_CARRY_SET = 4'h5,
    COND_NOT_EQUAL = 4'h6,
    COND_EQUAL = 4'h7,
    COND_OVF_CLEAR = 4'h8,
    COND_OVF_SET = 4'h9,
    COND_PLUS = 4'hA,
    COND_MINUS = 4'hB,
    COND_GREATER_EQ = 4'hC,
    COND_LESS = 4'hD,
    COND_GREATER = 4'hE,
    COND_LESS_EQ = 4'hF
  } sbbu_cond_t;

  // True for the operations that push a return point
  function automatic logic sbbu_is_call(input sbbu_op_t op);
    return (op == OP_RELATIVE_CALL) || (op == OP_ABSOLUTE_CALL) ||
           (op == OP_PAGE_CALL);
  endfunction

endpackage

// File: logic/sbbu_dp_if.sv
`timescale 1ns/1ps
// Operand path between the control part and the shift and bit datapath
interface sbbu_dp_if;
  import sbbu_pkg::*;
  sbbu_op_t op;
  logic word;
  logic [15:0] opnd;
  logic cin;
  logic [3:0] bitpos;
  logic [15:0] res;
  logic cout;
  logic vout;
  logic nout;
  logic zout;
  logic zbit;

  modport unit (
    output op, word, opnd, cin, bitpos,
    input res, cout, vout, nout, zout, zbit
  );
  modport alu (
    input op, word, opnd, cin, bitpos,
    output res, cout, vout, nout, zout, zbit
  );
endinterface

// File: logic/sbbu_alu.sv
`timescale 1ns/1ps
module sbbu_alu
  import sbbu_pkg::*;
#(
  parameter int W = 16
) (
  sbbu_dp_if.alu dp
);

  if (W != 16) begin : g_bad_w
    $error("sbbu_alu serves 16-bit operands only");
  end

  logic [15:0] val;
  logic [15:0] wres;
  logic [15:0] mask;
  logic msb;
  logic fill;

  // Shift, rotate and single-bit datapath, byte results keep the high byte
  always_comb begin
    val = dp.word ? dp.opnd : {8'h00, dp.opnd[7:0]};
    msb = dp.word ? dp.opnd[15] : dp.opnd[7];
    mask = 16'h0001 << dp.bitpos;
    wres = val;
    fill = 1'b0;
    dp.cout = dp.cin;
    case (dp.op)
      OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT, OP_ROTATE_LEFT,
      OP_ROTATE_LEFT_VIA_CARRY: begin
        if (dp.op == OP_ROTATE_LEFT) begin
          fill = msb;
        end else if (dp.op == OP_ROTATE_LEFT_VIA_CARRY) begin
          fill = dp.cin;
        end
        wres = {val[14:0], fill};
        dp.cout = msb;
      end
      OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_RIGHT,
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        if (dp.op == OP_ARITH_SHIFT_RIGHT) begin
          fill = msb;
        end else if (dp.op == OP_ROTATE_RIGHT) begin
          fill = val[0];
        end else if (dp.op == OP_ROTATE_RIGHT_VIA_CARRY) begin
          fill = dp.cin;
        end
        wres = dp.word ? {fill, val[15:1]} : {8'h00, fill, val[7:1]};
        dp.cout = val[0];
      end
      OP_BIT_SET: begin
        wres = val | mask;
      end
      OP_BIT_CLEAR: begin
        wres = val & ~mask;
      end
      OP_BIT_INVERT: begin
        wres = val ^ mask;
      end
      default: begin
        wres = val;
      end
    endcase
    dp.res = dp.word ? wres : {dp.opnd[15:8], wres[7:0]};
    dp.nout = dp.word ? wres[15] : wres[7];
    dp.zout = dp.word ? (wres == 16'h0000) : (wres[7:0] == 8'h00);
    // Overflow only when an arithmetic left shift flips the sign
    dp.vout = (dp.op == OP_ARITH_SHIFT_LEFT) &&
              (msb != (dp.word ? wres[15] : wres[7]));
    dp.zbit = ~val[dp.bitpos];
  end

endmodule

// File: logic/sbbu_cond.sv
`timescale 1ns/1ps
module sbbu_cond
  import sbbu_pkg::*;
(
  input sbbu_cond_t cond,
  input logic c,
  input logic z,
  input logic v,
  input logic n,
  output logic taken
);

  // Branch condition evaluation from the four flags
  always_comb begin
    case (cond)
      COND_ALWAYS: taken = 1'b1;
      COND_NEVER: taken = 1'b0;
      COND_HIGHER: taken = ~(c | z);
      COND_LOWER_SAME: taken = c | z;
      COND_CARRY_CLEAR: taken = ~c;
      COND_CARRY_SET: taken = c;
      COND_NOT_EQUAL: taken = ~z;
      COND_EQUAL: taken = z;
      COND_OVF_CLEAR: taken = ~v;
      COND_OVF_SET: taken = v;
      COND_PLUS: taken = ~n;
      COND_MINUS: taken = n;
      COND_GREATER_EQ: taken = ~(n ^ v);
      COND_LESS: taken = n ^ v;
      COND_GREATER: taken = ~(z | (n ^ v));
      COND_LESS_EQ: taken = z | (n ^ v);
      default: taken = 1'b0;
    endcase
  end

endmodule

// File: logic/sbbu_unit.sv
`timescale 1ns/1ps
`include "sbbu_consts.svh"
module sbbu_unit
  import sbbu_pkg::*;
#(
  parameter int PAGE_W = 8
) (
  input logic sys_clk,
  input logic rst_n,
  input logic start,
  input sbbu_op_t op,
  input logic is_word,
  input logic [15:0] opnd,
  input logic [3:0] ccr_in,
  input logic [3:0] bit_imm,
  input logic [15:0] bit_reg,
  input logic bit_from_reg,
  input sbbu_cond_t cond,
  input logic [15:0] disp,
  input logic [15:0] target,
  input logic [PAGE_W-1:0] target_page,
  input logic [15:0] next_pc,
  input logic [15:0] ret_addr,
  output logic done,
  output logic [15:0] result,
  output logic result_we,
  output logic [3:0] ccr_out,
  output logic [3:0] ccr_we,
  output logic [15:0] pc,
  output logic [PAGE_W-1:0] code_page,
  output logic pc_loaded,
  output logic ret_push,
  output logic [15:0] ret_push_addr,
  output logic [PAGE_W-1:0] ret_push_page,
  output logic ret_pop
);

  if (PAGE_W < 1 || PAGE_W > 16) begin : g_bad_page
    $error("PAGE_W must lie between 1 and 16");
  end

  sbbu_dp_if dp ();

  logic taken;
  logic [3:0] bit_src;
  logic done_ff, nxt_done;
  logic [15:0] result_ff, nxt_result;
  logic result_we_ff, nxt_result_we;
  logic [3:0] ccr_ff, nxt_ccr;
  logic [3:0] ccr_we_ff, nxt_ccr_we;
  logic [15:0] pc_ff, nxt_pc;
  logic [PAGE_W-1:0] page_ff, nxt_page;
  logic loaded_ff, nxt_loaded;
  logic push_ff, nxt_push;
  logic [15:0] push_addr_ff, nxt_push_addr;
  logic [PAGE_W-1:0] push_page_ff, nxt_push_page;
  logic pop_ff, nxt_pop;

  // Bit number source and fold to the operand size
  assign bit_src = bit_from_reg ? bit_reg[3:0] : bit_imm;
  assign dp.bitpos = is_word ? bit_src :
                     (bit_src & `SBBU_BYTE_POS_MASK);

  // Operand path into the datapath
  assign dp.op = op;
  assign dp.word = is_word;
  assign dp.opnd = opnd;
  assign dp.cin = ccr_in[`SBBU_FLG_C];

  sbbu_alu #(
    .W(16)
  ) u_alu (
    .dp(dp.alu)
  );

  sbbu_cond u_cond (
    .cond(cond),
    .c(ccr_in[`SBBU_FLG_C]),
    .z(ccr_in[`SBBU_FLG_Z]),
    .v(ccr_in[`SBBU_FLG_V]),
    .n(ccr_in[`SBBU_FLG_N]),
    .taken(taken)
  );

  // Next values for results, flags and program flow
  always_comb begin
    nxt_done = start;
    nxt_result = result_ff;
    nxt_result_we = 1'b0;
    nxt_ccr = ccr_ff;
    nxt_ccr_we = `SBBU_CCR_NONE;
    nxt_pc = pc_ff;
    nxt_page = page_ff;
    nxt_loaded = 1'b0;
    nxt_push = 1'b0;
    nxt_push_addr = push_addr_ff;
    nxt_push_page = push_page_ff;
    nxt_pop = 1'b0;
    if (start) begin
      nxt_pc = next_pc;
      if (sbbu_is_call(op)) begin
        nxt_push = 1'b1;
        nxt_push_addr = next_pc;
        nxt_push_page = page_ff;
      end
      case (op)
        OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
        OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY: begin
          nxt_result = dp.res;
          nxt_result_we = 1'b1;
          nxt_ccr[`SBBU_FLG_C] = dp.cout;
          nxt_ccr[`SBBU_FLG_V] = dp.vout;
          nxt_ccr[`SBBU_FLG_Z] = dp.zout;
          nxt_ccr[`SBBU_FLG_N] = dp.nout;
          nxt_ccr_we = `SBBU_CCR_ALL;
        end
        OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_INVERT: begin
          nxt_result = dp.res;
          nxt_result_we = 1'b1;
          nxt_ccr[`SBBU_FLG_Z] = dp.zbit;
          nxt_ccr_we = `SBBU_CCR_Z;
        end
        OP_BIT_TEST: begin
          nxt_ccr[`SBBU_FLG_Z] = dp.zbit;
          nxt_ccr_we = `SBBU_CCR_Z;
        end
        OP_COND_BRANCH: begin
          if (taken) begin
            nxt_pc = next_pc + disp;
            nxt_loaded = 1'b1;
          end
        end
        OP_SAME_PAGE_JUMP, OP_ABSOLUTE_CALL: begin
          nxt_pc = target;
          nxt_loaded = 1'b1;
        end
        OP_RELATIVE_CALL: begin
          nxt_pc = next_pc + disp;
          nxt_loaded = 1'b1;
        end
        OP_PAGE_JUMP, OP_PAGE_CALL: begin
          nxt_pc = target;
          nxt_page = target_page;
          nxt_loaded = 1'b1;
        end
        OP_SAME_PAGE_RETURN: begin
          nxt_pc = ret_addr;
          nxt_loaded = 1'b1;
          nxt_pop = 1'b1;
        end
        default: begin
          nxt_pc = next_pc;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      result_ff <= 16'h0000;
      result_we_ff <= 1'b0;
      ccr_ff <= 4'h0;
      ccr_we_ff <= `SBBU_CCR_NONE;
      pc_ff <= `SBBU_PC_RESET;
      page_ff <= PAGE_W'(`SBBU_PAGE_RESET);
      loaded_ff <= 1'b0;
      push_ff <= 1'b0;
      push_addr_ff <= 16'h0000;
      push_page_ff <= PAGE_W'(`SBBU_PAGE_RESET);
      pop_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      result_ff <= nxt_result;
      result_we_ff <= nxt_result_we;
      ccr_ff <= nxt_ccr;
      ccr_we_ff <= nxt_ccr_we;
      pc_ff <= nxt_pc;
      page_ff <= nxt_page;
      loaded_ff <= nxt_loaded;
      push_ff <= nxt_push;
      push_addr_ff <= nxt_push_addr;
      push_page_ff <= nxt_push_page;
      pop_ff <= nxt_pop;
    end
  end

  // Outputs straight from registers
  assign done = done_ff;
  assign result = result_ff;
  assign result_we = result_we_ff;
  assign ccr_out = ccr_ff;
  assign ccr_we = ccr_we_ff;
  assign pc = pc_ff;
  assign code_page = page_ff;
  assign pc_loaded = loaded_ff;
  assign ret_push = push_ff;
  assign ret_push_addr = push_addr_ff;
  assign ret_push_page = push_page_ff;
  assign ret_pop = pop_ff;

  // Checks on the registered answers
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_call_req;
    start && (op == OP_ABSOLUTE_CALL);
  endsequence

  // A call right behind this one may raise the push pulse again
  sequence s_call_done;
    ret_push && pc_loaded && (ret_push_addr == $past(next_pc))
    ##1 (!ret_push || $past(start));
  endsequence

  a_arith_left: assert property (
    start && op == OP_ARITH_SHIFT_LEFT && is_word
    |=> result == ($past(opnd) << 1) &&
    ccr_out[`SBBU_FLG_C] == $past(opnd[15]))
    else $error("arith left shift wrong");
  a_logic_right: assert property (
    start && op == OP_LOGIC_SHIFT_RIGHT &&
    is_word |=> result == ($past(opnd) >> 1) && result_we)
    else $error("logic right shift wrong");
  a_rotate_wrap: assert property (
    start && op == OP_ROTATE_LEFT && is_word
    |=> result == (($past(opnd) << 1) | ($past(opnd) >> 15)))
    else $error("rotate left wrong");
  a_carry_rotate: assert property (
    start && op == OP_ROTATE_LEFT_VIA_CARRY &&
    is_word |=> result[0] == $past(ccr_in[`SBBU_FLG_C]) &&
    ccr_out[`SBBU_FLG_C] == $past(opnd[15]))
    else $error("carry rotate wrong");
  a_shift_flags: assert property (
    start && op == OP_LOGIC_SHIFT_LEFT &&
    !is_word |=> ccr_we == `SBBU_CCR_ALL &&
    ccr_out[`SBBU_FLG_N] == result[7] &&
    ccr_out[`SBBU_FLG_Z] == (result[7:0] == 8'h00))
    else $error("shift flags wrong");
  a_bit_set_imm: assert property (
    start && op == OP_BIT_SET && is_word &&
    !bit_from_reg |=> result == ($past(opnd) | (16'h0001 << $past(bit_imm)))
    && ccr_we == `SBBU_CCR_Z)
    else $error("bit set wrong");
  a_bit_clear_z: assert property (
    start && op == OP_BIT_CLEAR && is_word
    |=> ccr_out[`SBBU_FLG_Z] == !(($past(opnd) & result) != $past(opnd)))
    else $error("bit clear Z wrong");
  a_bit_invert: assert property (
    start && op == OP_BIT_INVERT
    |=> result != $past(opnd) && result_we)
    else $error("bit invert left operand");
  a_bit_test_keep: assert property (
    start && op == OP_BIT_TEST
    |=> !result_we && ccr_we == `SBBU_CCR_Z)
    else $error("bit test wrote operand");
  a_reg_bitpos: assert property (
    start && op == OP_BIT_SET && bit_from_reg &&
    !is_word |=> result[15:8] == $past(opnd[15:8]) && result[7:0] != 8'h00)
    else $error("byte bit number not folded");
  a_cond_never: assert property (
    start && op == OP_COND_BRANCH &&
    cond == COND_NEVER |=> !pc_loaded && pc == $past(next_pc))
    else $error("never branch taken");
  a_cond_always: assert property (
    start && op == OP_COND_BRANCH &&
    cond == COND_ALWAYS |=> pc_loaded && pc == $past(next_pc) + $past(disp))
    else $error("always branch not taken");
  a_jump_same: assert property (
    start && op == OP_SAME_PAGE_JUMP
    |=> pc == $past(target) && $stable(code_page))
    else $error("same page jump wrong");
  a_call_push: assert property (
    s_call_req |=> s_call_done)
    else $error("call did not save return point");
  a_page_call: assert property (
    start && op == OP_PAGE_CALL
    |=> code_page == $past(target_page) && pc == $past(target) &&
    ret_push_page == $past(code_page))
    else $error("page call wrong");
  a_page_jump: assert property (
    start && op == OP_PAGE_JUMP
    |=> code_page == $past(target_page) && pc == $past(target) && !ret_push)
    else $error("page jump wrong");
  a_return_page: assert property (
    start && op == OP_SAME_PAGE_RETURN
    |=> pc == $past(ret_addr) && $stable(code_page) && ret_pop)
    else $error("return wrong");
  // Without an operation no pulse may reach the stack or the write-back
  a_pulse_idle: assert property (
    !start |=> !ret_push && !ret_pop && !pc_loaded && !result_we)
    else $error("pulse without an operation");

endmodule

// File: verif/sbbu_mem_model.sv
`timescale 1ns/1ps
// Far side: operand write-back cell and return-address stack
module sbbu_mem_model (
  input logic sys_clk,
  input logic rst_n,
  input logic [15:0] result,
  input logic result_we,
  input logic ret_push,
  input logic [15:0] ret_push_addr,
  input logic ret_pop,
  output logic [15:0] ret_addr,
  output logic [15:0] wb_val
);
  logic [15:0] stk [8];
  logic [2:0] sp_ff;

  // Stack and write-back cell update on the unit's pulses
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sp_ff <= 3'h0;
      wb_val <= 16'h0000;
      for (int i = 0; i < 8; i++) stk[i] <= 16'hA5A5;
    end else begin
      if (ret_push) begin
        stk[sp_ff] <= ret_push_addr;
        sp_ff <= sp_ff + 3'h1;
      end else if (ret_pop) begin
        sp_ff <= sp_ff - 3'h1;
      end
      if (result_we) wb_val <= result;
    end
  end

  // Top of stack offered as the saved return point
  assign ret_addr = stk[sp_ff - 3'h1];
endmodule

// File: verif/sbbu_unit_tb.sv
`timescale 1ns/1ps
module sbbu_unit_tb;
  import sbbu_pkg::*;
  logic sys_clk, rst_n, start, is_word, bit_from_reg, done, result_we;
  logic pc_loaded, ret_push, ret_pop, b;
  sbbu_op_t op;
  sbbu_cond_t cond;
  logic [15:0] opnd, bit_reg, disp, target, next_pc, ret_addr, result;
  logic [15:0] pc, ret_push_addr, wb_val, r;
  logic [3:0] ccr_in, bit_imm, ccr_out, ccr_we;
  logic [7:0] target_page, code_page, ret_push_page;
  logic [19:0] e;
  logic [15:0] sops [3] = '{16'h8001, 16'h4080, 16'h00C3};
  logic [15:0] bops [4] = '{16'h8000, 16'h00F7, 16'h0008, 16'hFF41};
  logic [15:0] bsrc [4] = '{16'h000F, 16'h000B, 16'h0013, 16'h000E};
  int errors = 0;
  int checks_done = 0;
  int p;

  sbbu_unit uut (.sys_clk, .rst_n, .start, .op, .is_word, .opnd, .ccr_in,
    .bit_imm, .bit_reg, .bit_from_reg, .cond, .disp, .target, .target_page,
    .next_pc, .ret_addr, .done, .result, .result_we, .ccr_out, .ccr_we, .pc,
    .code_page, .pc_loaded, .ret_push, .ret_push_addr, .ret_push_page,
    .ret_pop);
  sbbu_mem_model mem (.sys_clk, .rst_n, .result, .result_we, .ret_push,
    .ret_push_addr, .ret_pop, .ret_addr, .wb_val);

  // Clock at 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One operation: start for one cycle, then look at the answer
  task automatic exec(input sbbu_op_t o);
    @(negedge sys_clk);
    op = o;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    chk({15'h0, done}, 16'h0001);
  endtask

  // Jump, call or return with pc, page and transfer checks
  task automatic ctl(input sbbu_op_t o, input logic [15:0] t, npc, epc,
                     input logic [7:0] pg, epg);
    target = t;
    next_pc = npc;
    target_page = pg;
    exec(o);
    chk(pc, epc);
    chk({8'h0, code_page}, {8'h0, epg});
    chk({15'h0, pc_loaded}, 16'h0001);
  endtask

  // Expected shift result with flags {N,Z,V,C}
  function automatic logic [19:0] exp_sh(int k, logic w, logic [15:0] a,
                                         logic ci);
    logic [15:0] q;
    logic co, v, m;
    int t;
    t = w ? 15 : 7;
    m = a[t];
    q = (k[0] == 1'b0) ? (a << 1) : (a >> 1);
    co = (k[0] == 1'b0) ? m : a[0];
    case (k)
      1: q[t] = m;
      3: q[t] = 1'b0;
      4: q[0] = m;
      5: q[t] = a[0];
      6: q[0] = ci;
      7: q[t] = ci;
      default: ;
    endcase
    if (!w) q[15:8] = a[15:8];
    v = (k == 0) ? (m ^ q[t]) : 1'b0;
    return {q[t], (w ? q : {8'h0, q[7:0]}) == 16'h0, v, co, q};
  endfunction

  // Expected branch decision, flags C V Z N in bits 0..3
  function automatic logic cond_ok(int k, logic [3:0] f);
    logic c, v, z, n;
    {n, z, v, c} = f;
    case (k)
      0: return 1'b1;
      1: return 1'b0;
      2: return !(c | z);
      3: return c | z;
      4: return !c;
      5: return c;
      6: return !z;
      7: return z;
      8: return !v;
      9: return v;
      10: return !n;
      11: return n;
      12: return !(n ^ v);
      13: return n ^ v;
      14: return !(z | (n ^ v));
      default: return z | (n ^ v);
    endcase
  endfunction

  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    errors++;
    give_verdict;
  end

  // Main sequence
  initial begin
    {rst_n, start, is_word, bit_from_reg} = 4'h0;
    {opnd, bit_reg, disp, target, next_pc} = 80'h0;
    {ccr_in, bit_imm, target_page} = 16'h0;
    op = OP_ARITH_SHIFT_LEFT;
    cond = COND_ALWAYS;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(pc, 16'h0000);
    chk({8'h0, code_page}, 16'h0000);
    chk(result, 16'h0000);
    next_pc = 16'h0100;
    for (int i = 0; i < 8; i++) begin
      for (int w = 0; w < 2; w++) begin
        for (int j = 0; j < 3; j++) begin
          is_word = w[0];
          opnd = sops[j];
          ccr_in = {3'h0, j[0]};
          e = exp_sh(i, w[0], sops[j], j[0]);
          exec(sbbu_op_t'(i[4:0]));
          chk(result, e[15:0]);
          chk({12'h0, ccr_out}, {12'h0, e[19:16]});
          chk({12'h0, ccr_we}, 16'h000F);
          chk({15'h0, result_we}, 16'h0001);
          chk(pc, 16'h0100);
          @(negedge sys_clk);
          chk(wb_val, e[15:0]);
        end
      end
    end
    $display("test shifts and rotates done");
    for (int i = 8; i < 12; i++) begin
      for (int j = 0; j < 4; j++) begin
        is_word = ~j[0];
        bit_from_reg = j[1];
        bit_imm = bsrc[j][3:0];
        bit_reg = bsrc[j];
        opnd = bops[j];
        p = bsrc[j] & (j[0] ? 7 : 15);
        b = bops[j][p];
        r = bops[j];
        if (i == 8) r[p] = 1'b1;
        if (i == 9) r[p] = 1'b0;
        if (i == 10) r[p] = ~b;
        exec(sbbu_op_t'(i[4:0]));
        if (i != 11) chk(result, r);
        chk({15'h0, result_we}, {15'h0, i != 11});
        chk({15'h0, ccr_out[2]}, {15'h0, ~b});
        chk({12'h0, ccr_we}, 16'h0004);
      end
    end
    $display("test bit operations done");
    next_pc = 16'h1000;
    disp = 16'hFFF0;
    for (int k = 0; k < 16; k++) begin
      for (int f = 0; f < 16; f++) begin
        cond = sbbu_cond_t'(k[3:0]);
        ccr_in = f[3:0];
        b = cond_ok(k, f[3:0]);
        exec(OP_COND_BRANCH);
        chk(pc, b ? 16'h0FF0 : 16'h1000);
        chk({15'h0, pc_loaded}, {15'h0, b});
        chk({12'h0, ccr_we}, 16'h0000);
      end
    end
    $display("test branch conditions done");
    disp = 16'h0100;
    ctl(OP_SAME_PAGE_JUMP, 16'h1234, 16'h0002, 16'h1234,
        8'h55, 8'h00);
    ctl(OP_PAGE_JUMP, 16'h2000, 16'h1236, 16'h2000,
        8'h5A, 8'h5A);
    ctl(OP_RELATIVE_CALL, 16'h0000, 16'h2004, 16'h2104,
        8'h77, 8'h5A);
    chk(ret_push_addr, 16'h2004);
    chk({15'h0, ret_push}, 16'h0001);
    ctl(OP_ABSOLUTE_CALL, 16'h3000, 16'h2106, 16'h3000,
        8'h77, 8'h5A);
    chk(ret_push_addr, 16'h2106);
    ctl(OP_PAGE_CALL, 16'h0400, 16'h3002, 16'h0400,
        8'h33, 8'h33);
    chk(ret_push_addr, 16'h3002);
    chk({8'h0, ret_push_page}, 16'h005A);
    ctl(OP_SAME_PAGE_RETURN, 16'h0, 16'h0402, 16'h3002,
        8'h44, 8'h33);
    chk({15'h0, ret_pop}, 16'h0001);
    ctl(OP_SAME_PAGE_RETURN, 16'h0, 16'h3004, 16'h2106,
        8'h44, 8'h33);
    $display("test jumps calls returns done");
    give_verdict;
  end
endmodule
